// >>> design/nhi_map.vh
// register map, field positions, reset values and timing of the nfc host block
// assumes a 10 MHz system clock and byte addresses on the register bus
`ifndef NHI_MAP_VH
`define NHI_MAP_VH
`define NHI_CLK_HZ 10000000
`define NHI_BURST_US 100
`define NHI_POLL_MS 16'h0014
`define NHI_MS_CYCLES 10000
`define NHI_REG_CTRL 5'h00
`define NHI_REG_TECH 5'h04
`define NHI_REG_LISTEN 5'h08
`define NHI_REG_STATUS 5'h0C
`define NHI_REG_RXDATA 5'h10
`define NHI_REG_TXDATA 5'h14
`define NHI_CTRL_RUN 0
`define NHI_CTRL_LP 1
`define NHI_CTRL_POL 2
`define NHI_CTRL_XTAL 3
`define NHI_CTRL_NOTIFY 4
`define NHI_CTRL_RST 5'h00
`define NHI_TECH_RST 4'hF
`define NHI_LISTEN_RST 16'h01F4
`define NHI_ADDR_HDR 5'h0A
`define NHI_CLK_XTAL 2'h0
`define NHI_CLK_RF 2'h1
`define NHI_CLK_LP40 2'h2
`define NHI_CLK_LP380 2'h3
`endif

// >>> design/nhi_top.v
// nfc host interface: serial-bus slave, mode control and polling sequencer
// assumes a 10 MHz clock, an avalon-mm master and async pins from outside
//
// What this block does
// - idle mode: host link usable, radio stays off.
// - listener mode: enabled to listen, acting as card or peer target.
// - poller mode searches for tags; transmitter off when exchange ends.
// - loop alternates listening phase and polling phase, standby and active.
// - listening: standby without field, listener mode once field detected.
// - each technology has its own enable in the polling loop.
// - low-power polling: short field burst, full polling only if sensed.
// - listening phase length is configurable, typically 500 ms.
// - slave works at standard and fast clock rates.
// - wake and answer only on own slave address, ignore others.
// - slave may hold the clock low to pause; master must wait.
// - no general call, no 10-bit addressing, no fast-mode-plus.
// - address is 01010 then the two strap levels.
// - notification output to host with programmable active level.
// - pins act as serial bus only when nonvolatile config selects it.
// - shift register, bit timing and address compare done in hardware.
// - crystal clock times the radio in poller mode when enabled.
// - four clock sources: 27.12 MHz, 13.56 MHz, 40 MHz, 380 kHz.
// - standby leaves on serial wake, field detect or wake timer.
`timescale 1ns/1ps
`include "nhi_map.vh"
module nhi_top #(
   parameter MS_CYCLES = `NHI_MS_CYCLES
)(
   input wire clock,
   input wire rst,
   input wire [4:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   output reg [31:0] avs_readdata,
   output wire avs_waitrequest,
   input wire nvm_serial_host_sel,
   input wire addr_strap_low,
   input wire addr_strap_high,
   input wire serial_clock_pin_in,
   output wire serial_clock_pin_out,
   output wire serial_clock_pin_oe,
   input wire serial_data_pin_in,
   output wire serial_data_pin_out,
   output wire serial_data_pin_oe,
   output reg notify_pin,
   input wire rf_field_det,
   input wire rf_target_sensed,
   input wire rf_exchange_done,
   output reg rf_tx_on,
   output reg [3:0] tech_poll_en,
   output reg listen_en,
   output reg power_active,
   output reg [2:0] func_mode,
   output reg [1:0] rf_clk_sel
);
   localparam BURST_CYC = (`NHI_BURST_US * (`NHI_CLK_HZ / 1000000));
   localparam [9:0] BURST_LAST = BURST_CYC[9:0] - 10'h001;
   localparam [13:0] MS_LAST = MS_CYCLES[13:0] - 14'h0001;
   localparam [15:0] POLL_MS = `NHI_POLL_MS;
   // sequencer states
   localparam [4:0] P_IDLE = 5'h01;
   localparam [4:0] P_STBY = 5'h02;
   localparam [4:0] P_LISTEN = 5'h04;
   localparam [4:0] P_SENSE = 5'h08;
   localparam [4:0] P_POLL = 5'h10;
   // serial slave states
   localparam [6:0] S_IDLE = 7'h01;
   localparam [6:0] S_ADDR = 7'h02;
   localparam [6:0] S_AACK = 7'h04;
   localparam [6:0] S_RX = 7'h08;
   localparam [6:0] S_RACK = 7'h10;
   localparam [6:0] S_TX = 7'h20;
   localparam [6:0] S_TACK = 7'h40;

   // two-flop synchronisers for every pin from outside
   reg [7:0] sync1;
   reg [7:0] sync2;
   always @(posedge clock)
   begin
      if (rst)
      begin
         sync1 <= 8'hFF;
         sync2 <= 8'hFF;
      end
      else
      begin
         sync1 <= {rf_exchange_done, rf_target_sensed, rf_field_det,
                   nvm_serial_host_sel, addr_strap_high, addr_strap_low,
                   serial_data_pin_in, serial_clock_pin_in};
         sync2 <= sync1;
      end
   end
   wire scl = sync2[0];
   wire sda = sync2[1];
   wire host_sel = sync2[4];
   wire field = sync2[5];
   wire sensed = sync2[6];
   wire xchg_done = sync2[7];

   // registers
   reg [4:0] ctrl;
   reg [3:0] tech_en;
   reg [15:0] listen_ms;
   reg [7:0] rx_buf;
   reg rx_full;
   reg [7:0] tx_buf;
   reg tx_full;
   reg bus_ack;
   reg [4:0] pstate;
   reg [6:0] sstate;
   reg [6:0] own_addr;

   // one wait state per access; write and read take effect when it drops
   assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack;
   wire wr_go = avs_write & bus_ack;
   wire rd_go = avs_read & bus_ack;
   wire rx_load;
   wire tx_take;

   always @(posedge clock)
   begin
      if (rst)
      begin
         bus_ack <= 1'b0;
         avs_readdata <= 32'h00000000;
         ctrl <= `NHI_CTRL_RST;
         tech_en <= `NHI_TECH_RST;
         listen_ms <= `NHI_LISTEN_RST;
         tx_buf <= 8'h00;
      end
      else
      begin
         bus_ack <= (avs_read | avs_write) & ~bus_ack;
         if (avs_read & ~bus_ack)
         begin
            case (avs_address)
               `NHI_REG_CTRL: avs_readdata <= {27'h0, ctrl};
               `NHI_REG_TECH: avs_readdata <= {28'h0, tech_en};
               `NHI_REG_LISTEN: avs_readdata <= {16'h0, listen_ms};
               `NHI_REG_STATUS: avs_readdata <= {7'h0, own_addr, sstate,
                  rf_clk_sel, power_active, field, tx_full, rx_full,
                  pstate};
               `NHI_REG_RXDATA: avs_readdata <= {24'h0, rx_buf};
               default: avs_readdata <= 32'h00000000;
            endcase
         end
         if (wr_go)
         begin
            case (avs_address)
               `NHI_REG_CTRL: ctrl <= avs_writedata[4:0];
               `NHI_REG_TECH: tech_en <= avs_writedata[3:0];
               `NHI_REG_LISTEN: listen_ms <= avs_writedata[15:0];
               `NHI_REG_TXDATA: tx_buf <= avs_writedata[7:0];
               default: ;
            endcase
         end
      end
   end

   // byte flags: set wins over clear, hardware set for rx_full, software set for tx_full
   always @(posedge clock)
   begin
      if (rst)
      begin
         rx_full <= 1'b0;
         tx_full <= 1'b0;
      end
      else
      begin
         if (rx_load)
            rx_full <= 1'b1;
         else if (rd_go && avs_address == `NHI_REG_RXDATA)
            rx_full <= 1'b0;
         if (wr_go && avs_address == `NHI_REG_TXDATA)
            tx_full <= 1'b1;
         else if (tx_take)
            tx_full <= 1'b0;
      end
   end

   // notification line, level chosen by software
   always @(posedge clock)
   begin
      if (rst)
         notify_pin <= 1'b0;
      else
         notify_pin <= ctrl[`NHI_CTRL_NOTIFY] ^ ~ctrl[`NHI_CTRL_POL];
   end

   // serial slave, oversampled by the system clock: rates up to about
   // a tenth of it are safe, faster rates need a faster clock
   reg scl_q;
   reg sda_q;
   reg [7:0] shreg;
   reg [3:0] bitcnt;
   reg rw;
   reg hold;
   reg nack;
   reg sda_drv;
   wire scl_rise = scl & ~scl_q;
   wire scl_fall = ~scl & scl_q;
   wire start_c = scl & scl_q & sda_q & ~sda;
   wire stop_c = scl & scl_q & ~sda_q & sda;
   assign rx_load = sstate[3] & hold & ~rx_full;
   assign tx_take = (sstate[2] | sstate[6]) & hold & rw & tx_full;
   assign serial_data_pin_out = 1'b0;
   assign serial_clock_pin_out = 1'b0;
   assign serial_data_pin_oe = sda_drv & host_sel;
   assign serial_clock_pin_oe = hold & host_sel;

   always @(posedge clock)
   begin
      if (rst)
      begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         own_addr <= {`NHI_ADDR_HDR, 2'b00};
         sstate <= S_IDLE;
         shreg <= 8'h00;
         bitcnt <= 4'h0;
         rw <= 1'b0;
         hold <= 1'b0;
         nack <= 1'b0;
         sda_drv <= 1'b0;
         rx_buf <= 8'h00;
      end
      else
      begin
         scl_q <= scl;
         sda_q <= sda;
         if (sstate == S_IDLE)
            own_addr <= {`NHI_ADDR_HDR, sync2[3], sync2[2]};
         if (!host_sel)
         begin
            sstate <= S_IDLE;
            hold <= 1'b0;
            sda_drv <= 1'b0;
         end
         else if (start_c)
         begin
            sstate <= S_ADDR;
            bitcnt <= 4'h0;
            hold <= 1'b0;
            sda_drv <= 1'b0;
         end
         else if (stop_c)
         begin
            sstate <= S_IDLE;
            hold <= 1'b0;
            sda_drv <= 1'b0;
         end
         else
         begin
            case (sstate)
               S_IDLE: ;
               S_ADDR:
               begin
                  if (scl_rise)
                  begin
                     shreg <= {shreg[6:0], sda};
                     bitcnt <= bitcnt + 4'h1;
                  end
                  else if (scl_fall && bitcnt == 4'h8)
                  begin
                     // general call and 10-bit headers never match
                     if (shreg[7:1] == own_addr)
                     begin
                        rw <= shreg[0];
                        sda_drv <= 1'b1;
                        sstate <= S_AACK;
                     end
                     else
                        sstate <= S_IDLE;
                  end
               end
               S_AACK, S_TACK:
               begin
                  if (sstate == S_TACK && scl_rise)
                     nack <= sda;
                  if (scl_fall && !hold)
                  begin
                     sda_drv <= 1'b0;
                     bitcnt <= 4'h0;
                     if (sstate == S_TACK && nack)
                        sstate <= S_IDLE;
                     else if (rw)
                        hold <= 1'b1;
                     else
                        sstate <= S_RX;
                  end
                  else if (tx_take)
                  begin
                     hold <= 1'b0;
                     shreg <= tx_buf;
                     sda_drv <= ~tx_buf[7];
                     sstate <= S_TX;
                  end
               end
               S_RX:
               begin
                  if (scl_rise && !hold)
                  begin
                     shreg <= {shreg[6:0], sda};
                     bitcnt <= bitcnt + 4'h1;
                  end
                  else if (scl_fall && bitcnt == 4'h8)
                  begin
                     hold <= 1'b1;
                     bitcnt <= 4'h0;
                  end
                  else if (rx_load)
                  begin
                     // clock stays low until software empties the byte
                     rx_buf <= shreg;
                     hold <= 1'b0;
                     sda_drv <= 1'b1;
                     sstate <= S_RACK;
                  end
               end
               S_RACK:
               begin
                  if (scl_fall)
                  begin
                     sda_drv <= 1'b0;
                     sstate <= S_RX;
                  end
               end
               S_TX:
               begin
                  if (scl_fall)
                  begin
                     if (bitcnt == 4'h7)
                     begin
                        sda_drv <= 1'b0;
                        nack <= 1'b1;
                        sstate <= S_TACK;
                     end
                     else
                     begin
                        shreg <= {shreg[6:0], 1'b0};
                        sda_drv <= ~shreg[6];
                        bitcnt <= bitcnt + 4'h1;
                     end
                  end
               end
               default: sstate <= S_IDLE;
            endcase
         end
      end
   end
   // an address still being shifted in must not wake the device
   wire link_busy = ~sstate[0] & ~sstate[1];

   // polling-loop sequencer with millisecond timebase
   // loading a phase restarts the divider, so phases last whole ms
   reg [13:0] ms_div;
   reg [15:0] phase_ms;
   reg [9:0] burst_cnt;
   reg seen;
   wire ms_tick = (ms_div == MS_LAST);
   wire phase_end = ms_tick && phase_ms <= 16'h0001;
   wire [15:0] listen_len = (listen_ms == 16'h0000) ? 16'h0001 : listen_ms;

   always @(posedge clock)
   begin
      if (rst)
      begin
         pstate <= P_IDLE;
         ms_div <= 14'h0000;
         phase_ms <= 16'h0000;
         burst_cnt <= 10'h000;
         seen <= 1'b0;
      end
      else
      begin
         ms_div <= ms_tick ? 14'h0000 : ms_div + 14'h0001;
         if (ms_tick && phase_ms != 16'h0000)
            phase_ms <= phase_ms - 16'h0001;
         if (!ctrl[`NHI_CTRL_RUN])
            pstate <= P_IDLE;
         else
         begin
            case (pstate)
               P_IDLE:
               begin
                  pstate <= P_STBY;
                  phase_ms <= listen_len;
                  ms_div <= 14'h0000;
               end
               P_STBY, P_LISTEN:
               begin
                  if (field)
                     pstate <= P_LISTEN;
                  else if (phase_end)
                  begin
                     // wake timer ends the listening phase
                     burst_cnt <= 10'h000;
                     seen <= 1'b0;
                     if (tech_en == 4'h0)
                        phase_ms <= listen_len;
                     else if (ctrl[`NHI_CTRL_LP])
                        pstate <= P_SENSE;
                     else
                     begin
                        pstate <= P_POLL;
                        phase_ms <= POLL_MS;
                     end
                  end
                  else
                     pstate <= P_STBY;
               end
               P_SENSE:
               begin
                  burst_cnt <= burst_cnt + 10'h001;
                  if (sensed)
                     seen <= 1'b1;
                  if (burst_cnt == BURST_LAST)
                  begin
                     ms_div <= 14'h0000;
                     if (seen | sensed)
                     begin
                        pstate <= P_POLL;
                        phase_ms <= POLL_MS;
                     end
                     else
                     begin
                        pstate <= P_STBY;
                        phase_ms <= listen_len;
                     end
                  end
               end
               P_POLL:
               begin
                  if (xchg_done || phase_end)
                  begin
                     ms_div <= 14'h0000;
                     pstate <= P_STBY;
                     phase_ms <= listen_len;
                  end
               end
               default: pstate <= P_IDLE;
            endcase
         end
      end
   end

   // mode outputs and clock source choice, all registered
   always @(posedge clock)
   begin
      if (rst)
      begin
         rf_tx_on <= 1'b0;
         tech_poll_en <= 4'h0;
         listen_en <= 1'b0;
         power_active <= 1'b1;
         func_mode <= 3'b001;
         rf_clk_sel <= `NHI_CLK_LP40;
      end
      else
      begin
         rf_tx_on <= pstate[3] | pstate[4];
         tech_poll_en <= pstate[4] ? tech_en : 4'h0;
         listen_en <= pstate[2];
         // serial address match wakes the device from standby
         power_active <= ~pstate[1] | link_busy;
         func_mode <= {pstate[3] | pstate[4], pstate[2],
                       pstate[0] | pstate[1]};
         if ((pstate[3] | pstate[4]) && ctrl[`NHI_CTRL_XTAL])
            rf_clk_sel <= `NHI_CLK_XTAL;
         else if (pstate[2])
            rf_clk_sel <= `NHI_CLK_RF;
         else if (pstate[1] && !link_busy)
            rf_clk_sel <= `NHI_CLK_LP380;
         else
            rf_clk_sel <= `NHI_CLK_LP40;
      end
   end
endmodule

// >>> test/nhi_top_sva.sv
// assertions on the bus, pins and mode outputs of the nfc host block
// assumes it is bound into nhi_top and sees only its ports
`timescale 1ns/1ps
`include "nhi_map.vh"
module nhi_top_sva (
   input logic clock,
   input logic rst,
   input logic [4:0] avs_address,
   input logic avs_read,
   input logic avs_write,
   input logic [31:0] avs_writedata,
   input logic avs_waitrequest,
   input logic nvm_serial_host_sel,
   input logic serial_clock_pin_in,
   input logic serial_clock_pin_oe,
   input logic serial_data_pin_oe,
   input logic notify_pin,
   input logic rf_field_det,
   input logic rf_exchange_done,
   input logic rf_tx_on,
   input logic [3:0] tech_poll_en,
   input logic listen_en,
   input logic power_active,
   input logic [2:0] func_mode
);
   default clocking
      @(posedge clock);
   endclocking
   default disable iff (rst);
   sequence s_ctrl_ack;
      avs_write && !avs_waitrequest && avs_address == `NHI_REG_CTRL;
   endsequence
   property p_wait_first;
      $rose(avs_read || avs_write) |-> avs_waitrequest;
   endproperty
   a_wait_first: assert property (p_wait_first)
      else $error("new request answered without a wait state");
   property p_wait_one;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   a_wait_one: assert property (p_wait_one)
      else $error("request not answered in its second cycle");
   property p_idle_rf;
      func_mode == 3'b001 |-> !rf_tx_on;
   endproperty
   a_idle_rf: assert property (p_idle_rf)
      else $error("transmitter on in idle or standby");
   property p_listener;
      func_mode == 3'b010 |-> listen_en && !rf_tx_on;
   endproperty
   a_listener: assert property (p_listener)
      else $error("listener mode outside listening phase");
   property p_exch;
      rf_exchange_done && tech_poll_en != 4'h0
         |-> ##[1:7] tech_poll_en == 4'h0 && !rf_tx_on;
   endproperty
   a_exch: assert property (p_exch)
      else $error("transmitter kept on after exchange");
   property p_power;
      !power_active |-> func_mode == 3'b001 && !rf_tx_on;
   endproperty
   a_power: assert property (p_power)
      else $error("standby while radio active");
   property p_field;
      (listen_en && rf_field_det) [*6] |=> func_mode == 3'b010;
   endproperty
   a_field: assert property (p_field)
      else $error("field seen but no listener mode");
   property p_techoff;
      !rf_tx_on |-> tech_poll_en == 4'h0;
   endproperty
   a_techoff: assert property (p_techoff)
      else $error("technology enabled with transmitter off");
   property p_host_off;
      !nvm_serial_host_sel [*5]
         |-> !serial_clock_pin_oe && !serial_data_pin_oe;
   endproperty
   a_host_off: assert property (p_host_off)
      else $error("serial pins driven while not selected");
   property p_stretch;
      $rose(serial_clock_pin_oe) |-> !$past(serial_clock_pin_in);
   endproperty
   a_stretch: assert property (p_stretch)
      else $error("clock pulled low while high");
   property p_notify;
      s_ctrl_ack |-> ##2 notify_pin ==
         ($past(avs_writedata[4], 2) ^ !$past(avs_writedata[2], 2));
   endproperty
   a_notify: assert property (p_notify)
      else $error("notify level does not follow control");
endmodule
bind nhi_top nhi_top_sva chk_u (.*);

// >>> test/nhi_i2c_host.sv
// serial bus master model standing in for the host processor
// assumes pull-ups on both lines, resolved by the bench
`timescale 1ns/1ps
module nhi_i2c_host (
   input wire clock,
   input wire scl,
   input wire sda,
   output logic scl_lo,
   output logic sda_lo
);
   initial
   begin
      scl_lo = 1'b0;
      sda_lo = 1'b0;
   end
   task automatic tk(input int n);
      repeat (n) @(posedge clock);
   endtask
   // one 800 ns bit; data moves only while the clock is low
   task automatic bit_x(input logic b, output logic r);
   begin
      tk(1);
      sda_lo <= !b;
      tk(3);
      scl_lo <= 1'b0;
      tk(1);
      while (!scl) tk(1);
      r = sda;
      tk(3);
      scl_lo <= 1'b1;
   end
   endtask
   task automatic xbyte(input logic [7:0] d, input logic last,
      output logic [7:0] q, output logic ack);
      logic r;
   begin
      for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
      bit_x(last, r);
      ack = !r;
   end
   endtask
   task automatic sstart;
   begin
      tk(1);
      sda_lo <= 1'b0;
      tk(3);
      scl_lo <= 1'b0;
      tk(4);
      sda_lo <= 1'b1;
      tk(4);
      scl_lo <= 1'b1;
   end
   endtask
   task automatic sstop;
   begin
      tk(1);
      sda_lo <= 1'b1;
      tk(3);
      scl_lo <= 1'b0;
      tk(4);
      sda_lo <= 1'b0;
      tk(4);
   end
   endtask
endmodule

// >>> test/nfc_host_i2c_mode_control_test.sv
// self-checking bench for the nfc host block with a serial bus master
// assumes a 10 MHz clock and a shortened millisecond count
`timescale 1ns/1ps
`include "nhi_map.vh"
module nfc_host_i2c_mode_control_test;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest, scl_lo, sda_lo, scl_oe, sda_oe, notify_pin;
   logic host_sel = 1'b1;
   logic [1:0] strap = 2'h0;
   logic field = 1'b0;
   logic sensed = 1'b0;
   logic xdone = 1'b0;
   logic rf_tx_on, listen_en, power_active, a;
   logic [3:0] tech_poll_en, m;
   logic [2:0] func_mode;
   logic [1:0] rf_clk_sel;
   logic [31:0] q;
   logic [7:0] b;
   int n_errors = 0;
   int num_checks = 0;
   int cyc = 0;
   int n;
   wire scl = !(scl_lo || scl_oe);
   wire sda = !(sda_lo || sda_oe);
   nhi_top #(.MS_CYCLES(10)) dut_u (.clock(clock), .rst(rst),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .nvm_serial_host_sel(host_sel), .addr_strap_low(strap[0]),
      .addr_strap_high(strap[1]), .serial_clock_pin_in(scl),
      .serial_clock_pin_out(), .serial_clock_pin_oe(scl_oe),
      .serial_data_pin_in(sda), .serial_data_pin_out(),
      .serial_data_pin_oe(sda_oe), .notify_pin(notify_pin),
      .rf_field_det(field), .rf_target_sensed(sensed),
      .rf_exchange_done(xdone), .rf_tx_on(rf_tx_on),
      .tech_poll_en(tech_poll_en), .listen_en(listen_en),
      .power_active(power_active), .func_mode(func_mode),
      .rf_clk_sel(rf_clk_sel));
   nhi_i2c_host hm_u (.clock(clock), .scl(scl), .sda(sda),
      .scl_lo(scl_lo), .sda_lo(sda_lo));
   always #50 clock = !clock;
   task report_and_stop;
   begin
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   end
   endtask
   // hang guard, several times the expected run
   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_errors++;
         report_and_stop();
      end
   end
   task chk(input logic [31:0] g, input logic [31:0] e);
   begin
      num_checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   end
   endtask
   task bus(input logic w, input logic [4:0] ad, input logic [31:0] d);
   begin
      @(posedge clock);
      avs_address <= ad;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      @(posedge clock);
      while (avs_waitrequest !== 1'b0) @(posedge clock);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   end
   endtask
   task rd(input logic [4:0] ad, input logic [31:0] e);
   begin
      bus(1'b0, ad, 32'h0);
      chk(q, e);
   end
   endtask
   task i2c(input logic [7:0] ad, input logic [7:0] d);
      logic k;
   begin
      repeat (4) @(posedge clock);
      hm_u.sstart();
      hm_u.xbyte(ad, 1'b1, b, a);
      if (a) hm_u.xbyte(d, 1'b1, b, k);
      hm_u.sstop();
   end
   endtask
   task wmode(input logic [2:0] md);
   begin
      @(posedge clock);
      while (func_mode !== md) @(posedge clock);
      @(posedge clock);
   end
   endtask
   initial
   begin
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      rd(`NHI_REG_CTRL, 32'h0);
      chk(notify_pin, 1'b1);
      rd(`NHI_REG_TECH, 32'hF);
      rd(`NHI_REG_LISTEN, 32'h1F4);
      bus(1'b1, 5'h18, 32'hFFFF);
      rd(5'h18, 32'h0);
      rd(`NHI_REG_TXDATA, 32'h0);
      for (int i = 0; i < 4; i++)
      begin
         bus(1'b1, `NHI_REG_CTRL, {27'h0, i[1], 1'b0, i[0], 2'h0});
         repeat (3) @(posedge clock);
         chk(notify_pin, i[1] ^ !i[0]);
      end
      $display("test registers finished");
      for (int s = 0; s < 4; s++)
      begin
         strap <= s[1:0];
         i2c(8'h50 + 8'(2 * s), 8'hA0 + 8'(s));
         chk(a, 1'b1);
         rd(`NHI_REG_RXDATA, 32'hA0 + s);
         bus(1'b0, `NHI_REG_STATUS, 32'h0);
         chk(q[24:18], {5'b01010, s[1:0]});
      end
      i2c(8'h58, 8'h11);
      chk(a, 1'b0);
      i2c(8'h00, 8'h11);
      chk(a, 1'b0);
      host_sel <= 1'b0;
      i2c(8'h56, 8'h11);
      chk(a, 1'b0);
      host_sel <= 1'b1;
      fork
         i2c(8'h57, 8'hFF);
         begin
            repeat (200) @(posedge clock);
            bus(1'b1, `NHI_REG_TXDATA, 32'h3C);
         end
      join
      chk(b, 8'h3C);
      $display("test serial link finished");
      bus(1'b1, `NHI_REG_TECH, 32'h5);
      bus(1'b1, `NHI_REG_LISTEN, 32'h2);
      bus(1'b1, `NHI_REG_CTRL, 32'h9);
      wmode(3'b100);
      chk({tech_poll_en, rf_tx_on, rf_clk_sel}, 7'h2C);
      xdone <= 1'b1;
      while (func_mode !== 3'b001) @(posedge clock);
      xdone <= 1'b0;
      n = 0;
      while (func_mode === 3'b001)
      begin
         @(posedge clock);
         n++;
         if (n == 8) chk(power_active, 1'b0);
      end
      chk(32'(n >= 19 && n <= 21), 32'h1);
      field <= 1'b1;
      wmode(3'b010);
      chk({listen_en, rf_clk_sel}, 3'h5);
      field <= 1'b0;
      bus(1'b1, `NHI_REG_CTRL, 32'h0);
      repeat (6) @(posedge clock);
      chk({func_mode, rf_tx_on, listen_en}, 5'h04);
      bus(1'b1, `NHI_REG_CTRL, 32'h3);
      while (rf_tx_on !== 1'b1) @(posedge clock);
      n = 0;
      m = 4'h0;
      while (rf_tx_on === 1'b1)
      begin
         m = m | tech_poll_en;
         @(posedge clock);
         n++;
      end
      chk(32'(n >= 999 && n <= 1001), 32'h1);
      chk({m, func_mode}, 7'h01);
      sensed <= 1'b1;
      while (tech_poll_en !== 4'h5) @(posedge clock);
      chk(rf_tx_on, 1'b1);
      $display("test polling loop finished");
      report_and_stop();
   end
endmodule
